/* File: goc_pkg.sv */
// Purpose: Shared constants and carriers for the group offset code control
// Assumes: Two channel groups, 16-bit offset codes
// Notes: Default codes are nominal; trimmed values arrive as parameters
package goc_pkg;
  localparam int GOC_CODE_W = 16;
  localparam int GOC_GROUPS = 2;
  // Nominal straight-binary defaults, symmetric bipolar
  localparam logic [15:0] GOC_DEF_G6 = 16'h999A;
  localparam logic [15:0] GOC_DEF_G4 = 16'hAAAB;
  // Twos complement view flips the top bit
  localparam logic [15:0] GOC_FMT_FLIP = 16'h8000;
  localparam logic [15:0] GOC_CODE_RST = 16'h0000;
  localparam logic [15:0] GOC_FMT_KEEP = 16'h0000;
  // Reload runs for two sync edges plus one load edge
  localparam logic [1:0] GOC_WARM_RST = 2'h0;
  localparam logic [1:0] GOC_WARM_DONE = 2'h3;
  localparam logic [1:0] GOC_SYNC_RST = 2'h0;
  localparam logic GOC_GAIN_RST = 1'h1;
  localparam logic GOC_CONV_RST = 1'h0;

  typedef struct packed {
    logic valid;
    logic group;
    logic [15:0] code;
  } goc_write_t;

  typedef struct packed {
    logic [15:0] code;
    logic powered;
  } goc_group_out_t;
endpackage

/* File: goc_offset_ctrl.sv */
// Purpose: Holds and reloads the offset code of each channel group
// Assumes: Writes arrive decoded from the serial port on mclk
// Notes: Pins from outside pass two flip-flops before use
`timescale 1ns/100ps
module goc_offset_ctrl
  import goc_pkg::*;
#(
  parameter logic [15:0] TRIM_G6_A = GOC_DEF_G6,
  parameter logic [15:0] TRIM_G4_A = GOC_DEF_G4,
  parameter logic [15:0] TRIM_G6_B = GOC_DEF_G6,
  parameter logic [15:0] TRIM_G4_B = GOC_DEF_G4
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire goc_write_t wr,
  input wire logic gain_six,
  input wire logic data_format_select_pin,
  input wire logic single_supply_pin,
  output goc_group_out_t grp_a,
  output goc_group_out_t grp_b,
  output logic [15:0] code_binary_a,
  output logic [15:0] code_binary_b
);
  logic [1:0] fmt_sync;
  logic [1:0] next_fmt_sync;
  logic [1:0] sup_sync;
  logic [1:0] next_sup_sync;
  logic fmt_twos;
  logic single_sup;
  logic [15:0] fmt_mask;
  logic [1:0] warm;
  logic [1:0] next_warm;
  logic ready;
  logic gain_q;
  logic next_gain_q;
  logic gain_moved;
  logic reload;
  logic conv_on;
  logic next_conv_on;
  logic [15:0] code [GOC_GROUPS];
  logic [15:0] next_code [GOC_GROUPS];
  logic [15:0] bin [GOC_GROUPS];
  logic [15:0] next_bin [GOC_GROUPS];
  logic [15:0] dflt [GOC_GROUPS];
  logic [15:0] trim6 [GOC_GROUPS];
  logic [15:0] trim4 [GOC_GROUPS];

  // Trims are per part, so each group keeps its own
  assign trim6[0] = TRIM_G6_A;
  assign trim6[1] = TRIM_G6_B;
  assign trim4[0] = TRIM_G4_A;
  assign trim4[1] = TRIM_G4_B;

  // Pins are asynchronous to mclk
  always_comb
  begin
    next_fmt_sync = {fmt_sync[0], data_format_select_pin};
    next_sup_sync = {sup_sync[0], single_supply_pin};
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fmt_sync <= GOC_SYNC_RST;
      sup_sync <= GOC_SYNC_RST;
    end
    else
    begin
      fmt_sync <= next_fmt_sync;
      sup_sync <= next_sup_sync;
    end
  end

  // Only the second stage feeds any logic
  assign fmt_twos = fmt_sync[1];
  assign single_sup = sup_sync[1];

  // format mask for defaults and view
  always_comb
  begin
    if (fmt_twos)
    begin
      fmt_mask = GOC_FMT_FLIP;
    end
    else
    begin
      fmt_mask = GOC_FMT_KEEP;
    end
  end

  // keep reloading until both syncs settle
  always_comb
  begin
    next_gain_q = gain_six;
    if (warm != GOC_WARM_DONE)
    begin
      next_warm = warm + 2'h1;
    end
    else
    begin
      next_warm = warm;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      warm <= GOC_WARM_RST;
      gain_q <= GOC_GAIN_RST;
    end
    else
    begin
      warm <= next_warm;
      gain_q <= next_gain_q;
    end
  end

  // gain change detect
  // A write that meets a gain change is dropped
  assign ready = (warm == GOC_WARM_DONE);
  assign gain_moved = (gain_q != gain_six);
  assign reload = !ready || gain_moved;

  genvar g;
  generate
    for (g = 0; g < GOC_GROUPS; g++)
    begin : grp
      always_comb
      begin
        if (gain_six)
        begin
          dflt[g] = trim6[g] ^ fmt_mask;
        end
        else
        begin
          dflt[g] = trim4[g] ^ fmt_mask;
        end
      end

      always_comb
      begin
        next_code[g] = code[g];
        if (reload)
        begin
          next_code[g] = dflt[g];
        end
        else if (wr.valid && (wr.group == 1'(g)))
        begin
          next_code[g] = wr.code;
        end
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          code[g] <= GOC_CODE_RST;
        end
        else
        begin
          code[g] <= next_code[g];
        end
      end

      always_comb
      begin
        next_bin[g] = next_code[g] ^ fmt_mask;
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          bin[g] <= GOC_CODE_RST;
        end
        else
        begin
          bin[g] <= next_bin[g];
        end
      end
    end
  endgenerate

  // power down on single supply
  // Power-up held off until warm-up ends and the supply sync is valid
  always_comb
  begin
    next_conv_on = ready && !single_sup;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conv_on <= GOC_CONV_RST;
    end
    else
    begin
      conv_on <= next_conv_on;
    end
  end

  assign grp_a = '{code: code[0], powered: conv_on};
  assign grp_b = '{code: code[1], powered: conv_on};
  assign code_binary_a = bin[0];
  assign code_binary_b = bin[1];
endmodule

/* File: goc_sva.sv */
// Purpose: Checker for offset codes
// Assumes: Nominal trims
// Notes: Pin sync delay under five edges
`timescale 1ns/100ps
module goc_sva
  import goc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire goc_write_t wr,
  input wire logic gain_six,
  input wire logic data_format_select_pin,
  input wire logic single_supply_pin,
  input wire goc_group_out_t grp_a,
  input wire goc_group_out_t grp_b,
  input wire logic [15:0] code_binary_a,
  input wire logic [15:0] code_binary_b
);
  logic [1:0] warm;
  logic up;
  logic g;
  logic w;
  logic [15:0] d;
  logic [15:0] m;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Writes count only after warm-up and off gain edges
  assign up = (warm == GOC_WARM_DONE);
  assign w = up && wr.valid && g == gain_six;
  assign d = gain_six ? GOC_DEF_G6 : GOC_DEF_G4;
  assign m = data_format_select_pin ? GOC_FMT_FLIP : GOC_FMT_KEEP;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      warm <= GOC_WARM_RST;
      g <= GOC_GAIN_RST;
    end
    else
    begin
      warm <= (warm == GOC_WARM_DONE) ? warm : warm + 2'h1;
      g <= gain_six;
    end
  end
  a_write_a: assert property (w && !wr.group |=> grp_a.code == $past(wr.code))
    else $error("A write lost");
  a_write_b: assert property (w && wr.group |=> grp_b.code == $past(wr.code))
    else $error("B write lost");
  a_other_kept: assert property (w && wr.group |=> $stable(grp_a.code))
    else $error("A hit by B write");
  a_gain_load: assert property (up && g != gain_six |=> code_binary_a == $past(d))
    else $error("no gain reload");
  a_code_held: assert property (up && !wr.valid && g == gain_six |=> $stable(grp_a.code))
    else $error("A code drifted");
  a_reset_load: assert property ($rose(up) |-> code_binary_a == d && grp_a.code == (d ^ m) && grp_b.code == (d ^ m))
    else $error("bad reset default");
  a_bin_view: assert property (code_binary_a[14:0] == grp_a.code[14:0])
    else $error("binary view wrong");
  a_fmt_flip: assert property (data_format_select_pin [*4] |-> code_binary_a == (grp_a.code ^ GOC_FMT_FLIP))
    else $error("twos view not flipped");
  a_fmt_plain: assert property ((!data_format_select_pin) [*4] |-> code_binary_b == grp_b.code)
    else $error("binary view of B wrong");
  a_power_down: assert property (single_supply_pin [*5] |-> !grp_a.powered && !grp_b.powered)
    else $error("not powered down");
  cover property (w);
  cover property (up && g != gain_six);
  cover property (!grp_b.powered);
  cover property ($rose(up));
endmodule

/* File: tb_top.sv */
// Purpose: Bench for offset codes
// Assumes: Nominal trims
// Notes: Inputs move on falling edge
`timescale 1ns/100ps
module tb_top;
  import goc_pkg::*;
  logic mclk, rst_b, gain_six, fmt, ss;
  logic [15:0] ba, bb;
  goc_write_t wr;
  goc_group_out_t ga, gb;
  int fail_count, tests_run;
  logic [16:0] rows [4] = '{17'h01234, 17'h1ABCD, 17'h0FFFF, 17'h10000};
  goc_offset_ctrl dut_u (.mclk, .rst_b, .wr, .gain_six, .data_format_select_pin(fmt),
    .single_supply_pin(ss), .grp_a(ga), .grp_b(gb), .code_binary_a(ba), .code_binary_b(bb));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d bad %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    {rst_b, fmt, ss, wr} = '0;
    gain_six = 1'b1;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    chk(ga.code, 16'h999A);
    chk(ba, 16'h999A);
    chk({ga.powered, gb.powered}, 16'h0003);
    foreach (rows[i])
    begin
      wr = {1'b1, rows[i]};
      @(negedge mclk);
      chk(rows[i][16] ? gb.code : ga.code, rows[i][15:0]);
    end
    chk(ga.code, 16'hFFFF);
    // Write racing a gain change must lose
    {wr, gain_six} = {1'b1, 17'h05555, 1'b0};
    @(negedge mclk);
    wr.valid = 1'b0;
    chk(ga.code, 16'hAAAB);
    chk(gb.code, 16'hAAAB);
    fmt = 1'b1;
    repeat (3) @(negedge mclk);
    chk(ba, 16'h2AAB);
    gain_six = 1'b1;
    @(negedge mclk);
    chk(ga.code, 16'h199A);
    chk(bb, 16'h999A);
    ss = 1'b1;
    repeat (4) @(negedge mclk);
    chk({ga.powered, gb.powered}, 16'h0000);
    rst_b = 1'b0;
    @(negedge mclk);
    chk(ga.code, 16'h0000);
    {ss, rst_b} = 2'b01;
    repeat (4) @(negedge mclk);
    chk(gb.code, 16'h199A);
    chk({ga.powered, gb.powered}, 16'h0003);
    tally_and_finish;
  end
endmodule
bind goc_offset_ctrl goc_sva chk_u (
  .mclk(mclk),
  .rst_b(rst_b),
  .wr(wr),
  .gain_six(gain_six),
  .data_format_select_pin(data_format_select_pin),
  .single_supply_pin(single_supply_pin),
  .grp_a(grp_a),
  .grp_b(grp_b),
  .code_binary_a(code_binary_a),
  .code_binary_b(code_binary_b)
);
